// ### logic/memory_size_and_page_index_regs.v
// Memory allocation views, reserved test locations and program page index register
//
// How it works
// R01: Both reserved test locations read at any time; writes change nothing.
// R02: View A returns register, EEPROM and RAM switch levels; writes ignored.
// R03: Register space bit reads 1 for 2K, 0 for 1K.
// R04: EEPROM field: 00 none, 01 2K, 10 4K, 11 8K.
// R05: RAM field gives size in 2K steps, 2K up to 16K.
// R06: RAM smaller than its region is placed by the high-align bit.
// R07: RAM reset base follows from position reset value 09.
// R08: Program memory field: 00 none, 01 16K, 10 48K, 11 64K.
// R09: Paging field sets off-chip/on-chip split from 876K/128K to 0K/1M.
// R10: View B returns program memory and paging switches; writes ignored.
// R11: Page index always readable; reset and write right set by integration.
// R12: Page index maps a 16K page into window 8000 to BFFF.
// R13: Page index is an unsigned page number among 64 pages.
// R14: Ordinary bus write reaches the window one cycle later.
// R15: Far call and return read and load the index without the bus.
// R16: Far path load completes before the instruction ends.
// R17: Window access classed external or internal from partition and page.
// R18: Views show present switch levels with no stored copy; the code reads them through the two-stage synchroniser, two cycles late.
// R19: Upper page register bits read zero and ignore writes.
`timescale 1ns/1ps
`include "memory_size_and_page_index_regs_regs.vh"

module memory_size_and_page_index_regs #(
	parameter WRITE_SPECIAL_ONLY = 0,
	parameter ADDR_W = 11
) (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Core register bus
	input wire [ADDR_W-1:0] bus_addr,
	input wire bus_rd,
	input wire bus_wr,
	input wire [7:0] bus_wdata,
	output reg [7:0] bus_rdata_ff,
	output reg bus_rvalid_ff,
	output reg page_write_refused_ff,
	// Operating mode
	input wire special_mode,
	// Integration switches at the core boundary
	input wire register_space_alloc_bit,
	input wire [1:0] eeprom_alloc_field,
	input wire [2:0] ram_alloc_field,
	input wire [1:0] program_memory_alloc_field,
	input wire [1:0] paging_partition_field,
	// Far call and return path
	input wire far_load,
	input wire [5:0] far_page_in,
	output reg [5:0] far_page_ff,
	output reg far_ack_ff,
	// Paged window access
	input wire win_req,
	input wire [15:0] win_addr,
	output reg win_valid_ff,
	output reg win_hit_ff,
	output reg win_external_ff,
	output reg [19:0] win_phys_addr_ff,
	output reg [5:0] window_page_ff,
	// RAM position from the mapping logic
	input wire [7:0] ram_position,
	output reg [15:0] ram_size_ff,
	output reg [15:0] ram_region_ff,
	output reg [15:0] ram_base_ff,
	output reg [15:0] ram_reset_base_ff,
	// Decoded allocations
	output reg [11:0] reg_space_size_ff,
	output reg [15:0] eeprom_size_ff,
	output reg [16:0] program_memory_size_ff,
	output reg [9:0] offchip_kbytes_ff,
	output reg [10:0] onchip_kbytes_ff
);
	localparam SW_W = 10;
	localparam [5:0] PAGE_RESET = (WRITE_SPECIAL_ONLY != 0) ?
		`RESET_PAGE_SPECIAL_ONLY : `RESET_PAGE_ANY_MODE;
	localparam [ADDR_W-1:0] A_TEST_A = `OFS_RESERVED_TEST_A;
	localparam [ADDR_W-1:0] A_TEST_B = `OFS_RESERVED_TEST_B;
	localparam [ADDR_W-1:0] A_VIEW_A = `OFS_MEMORY_ALLOC_VIEW_A;
	localparam [ADDR_W-1:0] A_VIEW_B = `OFS_MEMORY_ALLOC_VIEW_B;
	localparam [ADDR_W-1:0] A_PAGE = `OFS_PROGRAM_WINDOW_PAGE_SELECT;

	// Switch bundle and its two-stage synchroniser
	wire [SW_W-1:0] sw_raw;
	reg [SW_W-1:0] sw_meta_ff;
	reg [SW_W-1:0] sw_sync_ff;
	wire sw_reg;
	wire [1:0] sw_eep;
	wire [2:0] sw_ram;
	wire [1:0] sw_rom;
	wire [1:0] sw_pag;

	// Page index state
	reg [5:0] page_ff;
	reg [5:0] nxt_page;
	wire page_sel;
	wire page_wr_ok;
	wire nxt_page_write_refused;

	// Read path
	reg [7:0] nxt_rdata;
	wire [7:0] view_a;
	wire [7:0] view_b;

	// Decoder results
	wire dec_hit;
	wire dec_external;
	wire [19:0] dec_phys;
	wire [15:0] ram_size_w;
	wire [15:0] ram_region_w;
	wire [15:0] ram_base_w;
	wire [15:0] ram_reset_base_w;
	reg [15:0] nxt_eeprom_size;
	reg [16:0] nxt_rom_size;
	reg [9:0] nxt_offchip;
	reg [10:0] nxt_onchip;
	reg [11:0] nxt_reg_space_size;

	// Straps may arrive from anywhere, so each bit is synchronised
	assign sw_raw = {register_space_alloc_bit, eeprom_alloc_field, ram_alloc_field,
		program_memory_alloc_field, paging_partition_field};

	genvar i;
	generate
		for (i = 0; i < SW_W; i = i + 1) begin : g_sw_sync
			always @(posedge core_clk) begin
				if (!nrst) begin
					sw_meta_ff[i] <= 1'b0;
					sw_sync_ff[i] <= 1'b0;
				end else begin
					sw_meta_ff[i] <= sw_raw[i];
					sw_sync_ff[i] <= sw_meta_ff[i];
				end
			end
		end
	endgenerate

	// Synchronised switch levels, two synchroniser flip-flops behind each view bit
	assign sw_reg = sw_sync_ff[9]; // [R18]
	assign sw_eep = sw_sync_ff[8:7];
	assign sw_ram = sw_sync_ff[6:4];
	assign sw_rom = sw_sync_ff[3:2];
	assign sw_pag = sw_sync_ff[1:0];

	// View A: register bit, EEPROM and RAM fields; gaps read zero
	assign view_a = {sw_reg, 1'b0, sw_eep, 1'b0, sw_ram}; // [R02] [R18]

	// View B: program memory field high, paging field low
	assign view_b = {sw_rom, 4'h0, sw_pag}; // [R10] [R18]

	// Page register write qualification
	assign page_sel = (bus_addr == A_PAGE);
	assign page_wr_ok = (WRITE_SPECIAL_ONLY == 0) || special_mode; // [R11]
	assign nxt_page_write_refused = bus_wr && page_sel && !page_wr_ok && !far_load; // [R11]

	// Far path wins a same-cycle collision; it finishes the instruction
	always @* begin
		nxt_page = page_ff;
		if (far_load) begin
			nxt_page = far_page_in; // [R15] [R16]
		end else if (bus_wr && page_sel && page_wr_ok) begin
			nxt_page = bus_wdata[5:0]; // [R11] [R19]
		end
	end

	// Page index register and the copy the window side sees
	always @(posedge core_clk) begin
		if (!nrst) begin
			page_ff <= PAGE_RESET; // [R11]
			window_page_ff <= PAGE_RESET;
		end else begin
			page_ff <= nxt_page; // [R14]
			window_page_ff <= nxt_page; // [R14]
		end
	end

	// Far path copy loads on the same edge, so the ack never leads the data
	always @(posedge core_clk) begin
		if (!nrst) begin
			far_page_ff <= PAGE_RESET;
			far_ack_ff <= 1'b0;
		end else begin
			far_page_ff <= nxt_page; // [R15]
			far_ack_ff <= far_load; // [R16]
		end
	end

	// Refused write pulse; a colliding far load hides it
	always @(posedge core_clk) begin
		if (!nrst) begin
			page_write_refused_ff <= 1'b0;
		end else begin
			page_write_refused_ff <= nxt_page_write_refused; // [R11]
		end
	end

	// Read mux; writes to views and test locations fall through untouched
	always @* begin
		case (bus_addr)
			A_TEST_A: nxt_rdata = 8'h00; // [R01]
			A_TEST_B: nxt_rdata = 8'h00; // [R01]
			A_VIEW_A: nxt_rdata = view_a; // [R02]
			A_VIEW_B: nxt_rdata = view_b; // [R10]
			A_PAGE: nxt_rdata = {2'b00, page_ff}; // [R11] [R19]
			default: nxt_rdata = `RESET_READ_DATA;
		endcase
	end

	// Read data stands until the next read
	always @(posedge core_clk) begin
		if (!nrst) begin
			bus_rdata_ff <= `RESET_READ_DATA;
			bus_rvalid_ff <= 1'b0;
		end else begin
			bus_rvalid_ff <= bus_rd;
			if (bus_rd) begin
				bus_rdata_ff <= nxt_rdata;
			end
		end
	end

	// Window decode uses the index already in force
	page_window_decode u_window (
		.cpu_addr(win_addr),
		.page(page_ff),
		.paging_partition_field(sw_pag),
		.win_hit(dec_hit),
		.win_external(dec_external),
		.phys_addr(dec_phys)
	);

	// Window result, one cycle behind the request
	always @(posedge core_clk) begin
		if (!nrst) begin
			win_valid_ff <= 1'b0;
			win_hit_ff <= 1'b0;
			win_external_ff <= 1'b0;
			win_phys_addr_ff <= 20'h00000;
		end else begin
			win_valid_ff <= win_req;
			win_hit_ff <= win_req && dec_hit; // [R12]
			win_external_ff <= win_req && dec_external; // [R17]
			win_phys_addr_ff <= dec_phys; // [R13]
		end
	end

	// Live RAM layout from the current position value
	ram_layout_decode u_ram_live (
		.ram_alloc_field(sw_ram),
		.ram_position(ram_position),
		.ram_size(ram_size_w),
		.ram_region(ram_region_w),
		.ram_base(ram_base_w)
	);

	// Reset layout from the position register's reset value
	ram_layout_decode u_ram_reset (
		.ram_alloc_field(sw_ram),
		.ram_position(`RESET_RAM_POSITION),
		.ram_size(),
		.ram_region(),
		.ram_base(ram_reset_base_w)
	);

	// Register space size from its single strap bit
	always @* begin
		case (sw_reg)
			1'b1: nxt_reg_space_size = `SIZE_2K_REG; // [R03]
			default: nxt_reg_space_size = `SIZE_1K_REG; // [R03]
		endcase
	end

	// EEPROM allocation size
	always @* begin
		case (sw_eep)
			2'b00: nxt_eeprom_size = 16'h0000; // [R04]
			2'b01: nxt_eeprom_size = `SIZE_2K; // [R04]
			2'b10: nxt_eeprom_size = `SIZE_4K; // [R04]
			default: nxt_eeprom_size = `SIZE_8K; // [R04]
		endcase
	end

	// Program memory allocation size
	always @* begin
		case (sw_rom)
			2'b00: nxt_rom_size = 17'h00000; // [R08]
			2'b01: nxt_rom_size = `ROM_SIZE_16K; // [R08]
			2'b10: nxt_rom_size = `ROM_SIZE_48K; // [R08]
			default: nxt_rom_size = `ROM_SIZE_64K; // [R08]
		endcase
	end

	// Off-chip and on-chip split in kilobytes, figures kept as printed
	always @* begin
		case (sw_pag)
			2'b00: begin
				nxt_offchip = 10'd876; // [R09]
				nxt_onchip = 11'd128;
			end
			2'b01: begin
				nxt_offchip = 10'd768; // [R09]
				nxt_onchip = 11'd256;
			end
			2'b10: begin
				nxt_offchip = 10'd512; // [R09]
				nxt_onchip = 11'd512;
			end
			default: begin
				nxt_offchip = 10'd0; // [R09]
				nxt_onchip = 11'd1024;
			end
		endcase
	end

	// Decoded strap sizes registered so every output leaves a flip-flop
	always @(posedge core_clk) begin
		if (!nrst) begin
			reg_space_size_ff <= `SIZE_1K_REG;
			eeprom_size_ff <= 16'h0000;
			program_memory_size_ff <= 17'h00000;
			offchip_kbytes_ff <= 10'd0;
			onchip_kbytes_ff <= 11'd0;
		end else begin
			reg_space_size_ff <= nxt_reg_space_size; // [R03]
			eeprom_size_ff <= nxt_eeprom_size;
			program_memory_size_ff <= nxt_rom_size;
			offchip_kbytes_ff <= nxt_offchip;
			onchip_kbytes_ff <= nxt_onchip;
		end
	end

	// RAM layout lags a position change by one cycle, like the size outputs
	always @(posedge core_clk) begin
		if (!nrst) begin
			ram_size_ff <= 16'h0000;
			ram_region_ff <= 16'h0000;
			ram_base_ff <= 16'h0000;
			ram_reset_base_ff <= 16'h0000;
		end else begin
			ram_size_ff <= ram_size_w; // [R05]
			ram_region_ff <= ram_region_w;
			ram_base_ff <= ram_base_w; // [R06]
			ram_reset_base_ff <= ram_reset_base_w; // [R07]
		end
	end
endmodule // memory_size_and_page_index_regs

// ### logic/memory_size_and_page_index_regs_regs.vh
// Register offsets, field positions and reset values for the memory size and page block
`ifndef MEMORY_SIZE_AND_PAGE_INDEX_REGS_REGS_VH
`define MEMORY_SIZE_AND_PAGE_INDEX_REGS_REGS_VH

// Register offsets within the register block
`define OFS_RESERVED_TEST_A 11'h014
`define OFS_RESERVED_TEST_B 11'h017
`define OFS_MEMORY_ALLOC_VIEW_A 11'h01C
`define OFS_MEMORY_ALLOC_VIEW_B 11'h01D
`define OFS_PROGRAM_WINDOW_PAGE_SELECT 11'h030

// Field positions in memory_alloc_view_a
`define POS_REGISTER_SPACE_ALLOC_BIT 7
`define POS_EEPROM_ALLOC_LSB 4
`define POS_RAM_ALLOC_LSB 0

// Field positions in memory_alloc_view_b
`define POS_PROGRAM_MEMORY_ALLOC_LSB 6
`define POS_PAGING_PARTITION_LSB 0

// Reset values
`define RESET_PAGE_ANY_MODE 6'h00
`define RESET_PAGE_SPECIAL_ONLY 6'h3C
`define RESET_RAM_POSITION 8'h09
`define RESET_READ_DATA 8'h00

// Paged program window
`define WIN_BASE 16'h8000
`define WIN_LAST 16'hBFFF

// First internal page per paging partition code
`define FIRST_INTERNAL_PAGE_00 6'h38
`define FIRST_INTERNAL_PAGE_01 6'h30
`define FIRST_INTERNAL_PAGE_10 6'h20
`define FIRST_INTERNAL_PAGE_11 6'h00

// Allocation sizes
`define SIZE_2K 16'h0800
`define SIZE_4K 16'h1000
`define SIZE_8K 16'h2000
`define SIZE_16K 16'h4000
`define SIZE_1K_REG 12'h400
`define SIZE_2K_REG 12'h800
`define ROM_SIZE_16K 17'h04000
`define ROM_SIZE_48K 17'h0C000
`define ROM_SIZE_64K 17'h10000

`endif

// ### logic/page_window_decode.v
// Paged program window hit, internal/external class and physical address
`timescale 1ns/1ps
`include "memory_size_and_page_index_regs_regs.vh"

module page_window_decode (
	// Access
	input wire [15:0] cpu_addr,
	input wire [5:0] page,
	input wire [1:0] paging_partition_field,
	// Result
	output wire win_hit,
	output wire win_external,
	output wire [19:0] phys_addr
);
	reg [5:0] first_internal;

	// Window covers 16K bytes from the window base
	assign win_hit = (cpu_addr >= `WIN_BASE) && (cpu_addr <= `WIN_LAST); // [R12]

	// Page number is the plain binary index, 64 pages of 16K
	assign phys_addr = {page, cpu_addr[13:0]}; // [R12] [R13]

	// Lowest page that lands on chip for each partition
	always @* begin
		case (paging_partition_field)
			2'b00: first_internal = `FIRST_INTERNAL_PAGE_00;
			2'b01: first_internal = `FIRST_INTERNAL_PAGE_01;
			2'b10: first_internal = `FIRST_INTERNAL_PAGE_10;
			default: first_internal = `FIRST_INTERNAL_PAGE_11;
		endcase
	end

	// Code 11 gives no external pages at all
	assign win_external = win_hit && (page < first_internal); // [R17]
endmodule // page_window_decode

// ### logic/ram_layout_decode.v
// RAM allocated size, mappable region and base address from allocation code
`timescale 1ns/1ps
`include "memory_size_and_page_index_regs_regs.vh"

module ram_layout_decode (
	// Configuration
	input wire [2:0] ram_alloc_field,
	input wire [7:0] ram_position,
	// Result
	output wire [15:0] ram_size,
	output reg [15:0] ram_region,
	output wire [15:0] ram_base
);
	reg [15:0] region_mask;
	wire [3:0] steps;
	wire [15:0] region_base;
	wire [15:0] high_gap;

	// Size grows in 2K steps, code 000 is 2K
	assign steps = {1'b0, ram_alloc_field} + 4'h1; // [R05]
	assign ram_size = {1'b0, steps, 11'h000}; // [R05]

	// Mappable region and the position bits it keeps
	always @* begin
		case (ram_alloc_field)
			3'b000: begin
				ram_region = `SIZE_2K;
				region_mask = 16'hF800;
			end
			3'b001: begin
				ram_region = `SIZE_4K;
				region_mask = 16'hF000;
			end
			3'b010, 3'b011: begin
				ram_region = `SIZE_8K;
				region_mask = 16'hE000;
			end
			default: begin
				ram_region = `SIZE_16K;
				region_mask = 16'hC000;
			end
		endcase
	end

	// Partial RAM sits at the top of its region when high-aligned
	assign region_base = {ram_position[7:3], 11'h000} & region_mask; // [R07]
	assign high_gap = ram_position[0] ? (ram_region - ram_size) : 16'h0000; // [R06]
	assign ram_base = region_base + high_gap; // [R06] [R07]
endmodule // ram_layout_decode

// ### dv/mem_regs_properties.sv
// Concurrent checks on the memory size and page index register ports
`timescale 1ns/1ps
module mem_regs_checker #(
	parameter WRITE_SPECIAL_ONLY = 0,
	parameter ADDR_W = 11
) (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Register bus
	input wire [ADDR_W-1:0] bus_addr,
	input wire bus_rd,
	input wire bus_wr,
	input wire [7:0] bus_wdata,
	input wire [7:0] bus_rdata_ff,
	input wire bus_rvalid_ff,
	input wire special_mode,
	// Far path
	input wire far_load,
	input wire [5:0] far_page_in,
	input wire [5:0] far_page_ff,
	input wire far_ack_ff,
	// Window
	input wire win_req,
	input wire [15:0] win_addr,
	input wire win_valid_ff,
	input wire win_hit_ff,
	input wire win_external_ff,
	input wire [19:0] win_phys_addr_ff,
	input wire [5:0] window_page_ff
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Test locations answer zero on the next cycle
	property p_tst; bus_rd && (bus_addr == 'h014 || bus_addr == 'h017) |=> bus_rvalid_ff && bus_rdata_ff == 8'h00; endproperty
	a_tst: assert property (p_tst) else $error("test location read wrong");
	// No answer without a read
	property p_norv; !bus_rd |=> !bus_rvalid_ff; endproperty
	a_norv: assert property (p_norv) else $error("stray read valid");
	// Writes elsewhere leave the page alone
	property p_keep; bus_wr && bus_addr != 'h030 && !far_load |=> $stable(window_page_ff); endproperty
	a_keep: assert property (p_keep) else $error("page moved by other write");
	// Permitted bus write lands one cycle later
	property p_wr; bus_wr && bus_addr == 'h030 && !far_load && (WRITE_SPECIAL_ONLY == 0 || special_mode) |=> {2'b00, window_page_ff} == ($past(bus_wdata) & 8'h3F); endproperty
	a_wr: assert property (p_wr) else $error("page write not in force");
	// Page read shows upper bits zero
	property p_rd; bus_rd && bus_addr == 'h030 |=> bus_rdata_ff == {2'b00, $past(window_page_ff)}; endproperty
	a_rd: assert property (p_rd) else $error("page read wrong");
	// Far load acknowledged with the loaded page
	property p_far; far_load |=> far_ack_ff && far_page_ff == $past(far_page_in); endproperty
	a_far: assert property (p_far) else $error("far load not done");
	// Far view and window view agree
	property p_same; far_ack_ff |-> window_page_ff == far_page_ff; endproperty
	a_same: assert property (p_same) else $error("far page differs");
	// Outside 8000..BFFF is no hit
	property p_miss; win_req && win_addr[15:14] != 2'b10 |=> win_valid_ff && !win_hit_ff; endproperty
	a_miss: assert property (p_miss) else $error("window hit outside");
	// Physical address is page number times 16K plus offset
	property p_phys; win_req |=> win_phys_addr_ff == {$past(window_page_ff), 14'h0000} + ($past(win_addr) & 16'h3FFF); endproperty
	a_phys: assert property (p_phys) else $error("physical address wrong");
	// Top page is internal in every partition
	property p_top; win_req && win_addr[15:14] == 2'b10 && window_page_ff == 6'h3F |=> win_hit_ff && !win_external_ff; endproperty
	a_top: assert property (p_top) else $error("top page classed external");
endmodule // mem_regs_checker

// ### dv/far_path_model.sv
// Far call and return page loader standing in for the core
`timescale 1ns/1ps
module far_path_model (
	// Clock
	input wire core_clk,
	// Far path
	output reg far_load,
	output reg [5:0] far_page_in
);
	// Idle at start; no load pending
	initial begin
		far_load = 1'b0;
		far_page_in = 6'h2A;
	end
	// One-cycle load beside the bus; data inverted once released
	task load(input [5:0] p);
		begin
			@(negedge core_clk);
			far_load = 1'b1;
			far_page_in = p;
			@(negedge core_clk);
			far_load = 1'b0;
			far_page_in = ~p;
		end
	endtask
endmodule // far_path_model

// ### dv/memory_size_and_page_index_regs_tb_top.sv
// Self-checking bench for the memory size and page index registers
`timescale 1ns/1ps
module memory_size_and_page_index_regs_tb_top;
	reg core_clk, nrst, bus_rd, bus_wr, special_mode, reg_sw, win_req;
	reg [10:0] bus_addr;
	reg [7:0] bus_wdata, ram_position, v;
	reg [1:0] eep, rom, pag;
	reg [2:0] ram;
	reg [15:0] win_addr;
	reg [6:0] fi;
	wire far_load, far_ack_ff, bus_rvalid_ff, win_valid_ff, win_hit_ff, win_external_ff;
	wire refused, s_refused;
	wire [5:0] far_page_in, far_page_ff, window_page_ff, s_page;
	wire [7:0] bus_rdata_ff, s_rdata;
	wire [19:0] win_phys_addr_ff;
	wire [15:0] ram_size_ff, ram_region_ff, ram_base_ff, ram_reset_base_ff, eeprom_size_ff;
	wire [11:0] reg_space_size_ff;
	wire [16:0] program_memory_size_ff;
	wire [9:0] offchip_kbytes_ff;
	wire [10:0] onchip_kbytes_ff;
	integer bad_count, check_count, cyc, i, j;
	memory_size_and_page_index_regs #(.WRITE_SPECIAL_ONLY(0), .ADDR_W(11)) dut_u (
		.core_clk(core_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_rd(bus_rd),
		.bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff),
		.bus_rvalid_ff(bus_rvalid_ff), .page_write_refused_ff(refused), .special_mode(special_mode),
		.register_space_alloc_bit(reg_sw), .eeprom_alloc_field(eep), .ram_alloc_field(ram),
		.program_memory_alloc_field(rom), .paging_partition_field(pag), .far_load(far_load),
		.far_page_in(far_page_in), .far_page_ff(far_page_ff), .far_ack_ff(far_ack_ff),
		.win_req(win_req), .win_addr(win_addr), .win_valid_ff(win_valid_ff),
		.win_hit_ff(win_hit_ff), .win_external_ff(win_external_ff),
		.win_phys_addr_ff(win_phys_addr_ff), .window_page_ff(window_page_ff),
		.ram_position(ram_position), .ram_size_ff(ram_size_ff), .ram_region_ff(ram_region_ff),
		.ram_base_ff(ram_base_ff), .ram_reset_base_ff(ram_reset_base_ff),
		.reg_space_size_ff(reg_space_size_ff), .eeprom_size_ff(eeprom_size_ff),
		.program_memory_size_ff(program_memory_size_ff), .offchip_kbytes_ff(offchip_kbytes_ff),
		.onchip_kbytes_ff(onchip_kbytes_ff));
	far_path_model fp_u (.core_clk(core_clk), .far_load(far_load), .far_page_in(far_page_in));
	// Second build: index resets to 3C and takes bus writes in special mode only
	memory_size_and_page_index_regs #(.WRITE_SPECIAL_ONLY(1), .ADDR_W(11)) dut_s_u (
		.core_clk(core_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_rd(bus_rd),
		.bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata_ff(s_rdata), .bus_rvalid_ff(),
		.page_write_refused_ff(s_refused), .special_mode(special_mode),
		.register_space_alloc_bit(reg_sw), .eeprom_alloc_field(eep), .ram_alloc_field(ram),
		.program_memory_alloc_field(rom), .paging_partition_field(pag), .far_load(far_load),
		.far_page_in(far_page_in), .far_page_ff(), .far_ack_ff(), .win_req(win_req),
		.win_addr(win_addr), .win_valid_ff(), .win_hit_ff(), .win_external_ff(),
		.win_phys_addr_ff(), .window_page_ff(s_page), .ram_position(ram_position),
		.ram_size_ff(), .ram_region_ff(), .ram_base_ff(), .ram_reset_base_ff(),
		.reg_space_size_ff(), .eeprom_size_ff(), .program_memory_size_ff(),
		.offchip_kbytes_ff(), .onchip_kbytes_ff());
	// Mappable region per RAM code
	function [15:0] region(input [2:0] c);
		region = c == 0 ? 16'h0800 : c == 1 ? 16'h1000 : c < 4 ? 16'h2000 : 16'h4000;
	endfunction
	// Base: position bits masked to the region, pushed up when high-aligned
	function [15:0] rbase(input [2:0] c, input [7:0] p);
		rbase = ({p[7:3], 11'h000} & ~(region(c) - 16'h0001))
			+ (p[0] ? region(c) - (c + 16'h0001) * 16'h0800 : 16'h0000);
	endfunction
	// Reset base per RAM code, position register at its reset value
	function [15:0] rst_base(input [2:0] c);
		rst_base = (c == 3'd4) ? 16'h1800 : (c == 3'd5) ? 16'h1000 : c[0] ? 16'h0000 : 16'h0800;
	endfunction
	// Compare and count
	task chk(input [19:0] seen, input [19:0] exp, input string nm);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("ERROR %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// Bus write, one strobe cycle
	task wr(input [10:0] a, input [7:0] d);
		begin
			@(negedge core_clk);
			bus_addr = a;
			bus_wdata = d;
			bus_wr = 1'b1;
			@(negedge core_clk);
			bus_wr = 1'b0;
		end
	endtask
	// Bus read, answer checked one cycle later
	task rd(input [10:0] a, input [7:0] e, input string nm);
		begin
			@(negedge core_clk);
			bus_addr = a;
			bus_rd = 1'b1;
			@(negedge core_clk);
			bus_rd = 1'b0;
			chk(bus_rvalid_ff, 1'b1, "rvalid");
			chk(bus_rdata_ff, e, nm);
		end
	endtask
	// Window access with expected class and address
	task win(input [15:0] a, input [5:0] pg, input h, input x);
		begin
			@(negedge core_clk);
			win_addr = a;
			win_req = 1'b1;
			@(negedge core_clk);
			win_req = 1'b0;
			chk(win_valid_ff, 1'b1, "valid");
			chk(win_hit_ff, h, "hit");
			chk(win_external_ff, x, "external");
			chk(win_phys_addr_ff, {pg, a[13:0]}, "phys");
		end
	endtask
	// Verdict and stop
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", check_count, bad_count);
			if (bad_count == 0 && check_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Free-running 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			bad_count = bad_count + 1;
			end_sim;
		end
	end
	initial begin
		{bus_rd, bus_wr, win_req, special_mode, reg_sw} = 5'h00;
		{bus_addr, bus_wdata, win_addr, eep, rom, pag, ram} = 0;
		ram_position = 8'h09;
		{bad_count, check_count, cyc} = 0;
		nrst = 1'b0;
		v = $urandom(32'hC50FE02E);
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		rd(11'h030, 8'h00, "page reset");
		chk(s_page, 6'h3C, "special build reset");
		chk(s_rdata, 8'h3C, "special build reset read");
		wr(11'h014, 8'hFF);
		wr(11'h017, 8'hFF);
		rd(11'h014, 8'h00, "test a");
		rd(11'h017, 8'h00, "test b");
		rd(11'h7FF, 8'h00, "unmapped");
		$display("test reset and reserved done");
		for (i = 0; i < 8; i = i + 1) begin
			{special_mode, reg_sw, eep, rom, pag} = $urandom;
			ram = i;
			ram_position = (i == 2) ? 8'h08 : $urandom;
			repeat (4) @(negedge core_clk);
			rd(11'h01C, {reg_sw, 1'b0, eep, 1'b0, ram}, "view a");
			rd(11'h01D, {rom, 4'h0, pag}, "view b");
			wr(11'h01C, $urandom);
			wr(11'h01D, $urandom);
			rd(11'h01C, {reg_sw, 1'b0, eep, 1'b0, ram}, "view a kept");
			chk(reg_space_size_ff, reg_sw ? 12'h800 : 12'h400, "reg size");
			chk(eeprom_size_ff, eep == 0 ? 16'h0000 : 16'h0400 << eep, "eeprom");
			chk(ram_size_ff, (i + 1) * 16'h0800, "ram size");
			chk(ram_region_ff, region(ram), "region");
			chk(ram_base_ff, rbase(ram, ram_position), "base");
			chk(ram_reset_base_ff, rst_base(ram), "reset base");
			chk(program_memory_size_ff, rom == 0 ? 17'h0 : rom == 1 ? 17'h04000
				: rom == 2 ? 17'h0C000 : 17'h10000, "rom size");
			chk(offchip_kbytes_ff, pag == 0 ? 876 : pag == 1 ? 768 : pag == 2 ? 512 : 0, "off");
			chk(onchip_kbytes_ff, 11'd128 << pag, "on");
		end
		$display("test views done");
		special_mode = 1'b0;
		for (i = 0; i < 7; i = i + 1) begin
			v = (i == 0) ? 8'hFF : $urandom;
			wr(11'h030, v);
			chk(window_page_ff, v[5:0], "page in force");
			chk(refused, 1'b0, "refused any mode");
			chk(s_refused, 1'b1, "refused outside special");
			chk(s_page, 6'h3C, "page kept outside special");
			rd(11'h030, {2'b00, v[5:0]}, "page read");
		end
		// Special mode opens the page register of the special-only build
		special_mode = 1'b1;
		wr(11'h030, 8'hC7);
		chk(s_refused, 1'b0, "special write accepted");
		chk(s_page, 6'h07, "special write");
		rd(11'h030, 8'h07, "page read");
		chk(s_rdata, 8'h07, "special page read");
		fp_u.load(6'h3F);
		chk(far_ack_ff, 1'b1, "far ack");
		chk(far_page_ff, 6'h3F, "far page");
		chk(s_page, 6'h3F, "far load special build");
		fork
			wr(11'h030, 8'h11);
			fp_u.load(6'h2A);
		join
		rd(11'h030, 8'h2A, "far wins");
		$display("test page register done");
		for (j = 0; j < 4; j = j + 1) begin
			pag = j;
			fi = (j == 3) ? 7'h00 : 7'h40 - (7'h08 << j);
			repeat (3) @(negedge core_clk);
			for (i = 0; i < 2; i = i + 1) begin
				v = {1'b0, fi} - i;
				wr(11'h030, v);
				win(16'h8000 | $urandom % 16'h4000, v[5:0], 1'b1, {1'b0, v[5:0]} < fi);
			end
			win(16'hC000, v[5:0], 1'b0, 1'b0);
		end
		$display("test window done");
		end_sim;
	end
endmodule // memory_size_and_page_index_regs_tb_top
bind memory_size_and_page_index_regs mem_regs_checker #(
	.WRITE_SPECIAL_ONLY(WRITE_SPECIAL_ONLY), .ADDR_W(ADDR_W)) chk_u (
	.core_clk(core_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_rd(bus_rd),
	.bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff),
	.bus_rvalid_ff(bus_rvalid_ff), .special_mode(special_mode), .far_load(far_load),
	.far_page_in(far_page_in), .far_page_ff(far_page_ff), .far_ack_ff(far_ack_ff),
	.win_req(win_req), .win_addr(win_addr), .win_valid_ff(win_valid_ff),
	.win_hit_ff(win_hit_ff), .win_external_ff(win_external_ff),
	.win_phys_addr_ff(win_phys_addr_ff), .window_page_ff(window_page_ff));
